// file: bench/pn_lab_partner.sv
// lab-side bit clock source for both generators
`timescale 1ns/1ps
module pn_lab_partner (
    input  wire logic       run_i,
    output logic      [1:0] bit_clock_o
);
    // stands low between bursts so a burst is a whole count of bits
    initial begin
        bit_clock_o = 2'h0;
        forever begin
            wait (run_i);
            #100 bit_clock_o = 2'h3;
            #100 bit_clock_o = 2'h0;
        end
    end
endmodule // pn_lab_partner

// file: bench/pn_sequence_source_xor_bench.sv
// self-checking bench for the sequence source
`timescale 1ns/1ps
`include "pn_source_params.svh"
module pn_sequence_source_xor_bench;
    import pn_source_pkg::*;
    logic core_clk_i = 1'b0, resetn_i = 1'b0, use_custom_store_i = 1'b0, run = 1'b0;
    logic [1:0] bit_clock_i, sequence_restart_input_i = 2'h0, restart_button_i = 2'h0;
    logic [1:0] xor_a_i = 2'h0, xor_b_i = 2'h0, chip_stream_ready_i = 2'h3;
    logic [1:0] chip_sequence_out_o, frame_marker_o, chip_stream_valid_o;
    logic [1:0] chip_overflow_o, xor_logic_o, chk_en = 2'h0;
    sel_t       sequence_selector_i [2] = '{4'h0, 4'h0};
    bit_idx_t   long_len_i = 14'h0007, short_len_i = 14'h0005;
    store_wr_s  store_wr_i = '0;
    bipolar_t   chip_bipolar_o [2], xor_bipolar_o [2];
    chip_word_s chip_stream_data_o [2];
    logic [1:0] q [2][$];
    logic [7:0] pat [2][10];
    int         num_errors = 0, tests_run = 0;

    pn_sequence_source_xor u_pn_sequence_source_xor (.*);
    pn_lab_partner u_pn_lab_partner (.run_i(run), .bit_clock_o(bit_clock_i));
    initial forever #12.5 core_clk_i = ~core_clk_i;
////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [2:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic int ln(input int s);
        return (s inside {4, 5, 8, 9}) ? int'(short_len_i) : int'(long_len_i);
    endfunction
    task automatic expect_chips(input int g, s, n);
        int idx;
        for (int k = 1; k <= n; k++) begin
            idx = k % ln(s);
            q[g].push_back({idx == 0, pat[g][s][idx]});
        end
    endtask
    // built-in sequences: right shift, feedback into the top bit of the length in use
    function automatic bit_idx_t lfsr_next(input bit_idx_t st, input bit shrt);
        bit_idx_t r;
        r = st >> 1;
        if (shrt) r[`PN_SHORT_MSB] = ^(st & `PN_SHORT_TAPS);
        else r[`PN_IDX_W-1] = ^(st & `PN_LONG_TAPS);
        return r;
    endfunction
    task automatic expect_lfsr(input int g, s, n);
        bit_idx_t st;
        int       idx;
        st = 14'(s + 1);
        idx = 0;
        for (int k = 1; k <= n; k++) begin
            idx = (idx + 1) % ln(s);
            st = (idx == 0) ? 14'(s + 1) : lfsr_next(st, s inside {4, 5, 8, 9});
            q[g].push_back({idx == 0, st[0]});
        end
    endtask
    task automatic restart_both();
        repeat (4) @(negedge core_clk_i);
        sequence_restart_input_i = 2'h1;
        restart_button_i = 2'h2;
        repeat (2) @(negedge core_clk_i);
        sequence_restart_input_i = 2'h0;
        restart_button_i = 2'h0;
        repeat (10) @(negedge core_clk_i);
        chk({1'b0, frame_marker_o}, 3'h3);
    endtask
    task automatic steps(input int n);
        run = 1'b1;
        #(n * 200 - 50) run = 1'b0;
        repeat (12) @(negedge core_clk_i);
    endtask
    // compares only while enabled, so restart words leave no stale notes;
    // looks just after the falling edge: stimulus settled, pop not yet taken
    always @(negedge core_clk_i) begin
        #1;
        for (int g = 0; g < 2; g++)
            if (chk_en[g] && chip_stream_valid_o[g] && chip_stream_ready_i[g]) begin
                if (q[g].size() == 0) chk(3'h7, 3'h0);
                else chk({1'b0, chip_stream_data_o[g]}, {1'b0, q[g].pop_front()});
            end
    end
    initial begin
        #1000000 num_errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h0000_5d85));
        repeat (2) @(negedge core_clk_i);
        resetn_i = 1'b1;
        repeat (32) begin
            @(negedge core_clk_i);
            {xor_a_i, xor_b_i} = 4'($urandom);
            #1;
            for (int g = 0; g < 2; g++) begin
                chk(xor_bipolar_o[g], (xor_a_i[g] ^ xor_b_i[g]) ? `PN_BIP_POS : `PN_BIP_NEG);
                chk(xor_logic_o[g], xor_a_i[g] ^ xor_b_i[g]);
            end
        end
        $display("xor test done");
        for (int g = 0; g < 2; g++)
            for (int s = 0; s < 10; s++) begin
                pat[g][s] = 8'($urandom);
                for (int i = 0; i < 8; i++) begin
                    @(negedge core_clk_i);
                    store_wr_i = '{1'b1, g[0], 4'(s), 14'(i), pat[g][s][i]};
                end
            end
        @(negedge core_clk_i);
        store_wr_i.wr_en = 1'b0;
        use_custom_store_i = 1'b1;
        for (int s = 0; s < 10; s++) begin
            sequence_selector_i = '{4'(s), 4'(9 - s)};
            restart_both();
            chk({1'b0, chip_sequence_out_o}, {1'b0, pat[1][9 - s][0], pat[0][s][0]});
            expect_chips(0, s, 9);
            expect_chips(1, 9 - s, 9);
            chk_en = 2'h3;
            steps(9);
            chk({2'h0, (q[0].size() + q[1].size()) != 0}, 3'h0);
            chk_en = 2'h0;
        end
        $display("sequence test done");
        sequence_selector_i = '{4'h4, 4'h9};
        restart_both();
        expect_chips(0, 4, 16);
        chip_stream_ready_i = 2'h2;
        chk_en = 2'h1;
        steps(20);
        chk({2'h0, chip_overflow_o[0]}, 3'h1);
        repeat (200) begin
            @(negedge core_clk_i);
            chip_stream_ready_i[0] = 1'($urandom);
        end
        chk({2'h0, q[0].size() != 0}, 3'h0);
        $display("buffer test done");
        chk_en = 2'h0;
        chip_stream_ready_i = 2'h3;
        use_custom_store_i = 1'b0;
        short_len_i = 14'h0007;
        sequence_selector_i = '{4'h5, 4'h2};
        restart_both();
        // seeds are selector plus one: 6 and 3, low bits 0 and 1
        chk({1'b0, chip_sequence_out_o}, 3'h2);
        chk(chip_bipolar_o[0] | chip_bipolar_o[1], `PN_BIP_ZERO);
        expect_lfsr(0, 5, 9);
        expect_lfsr(1, 2, 9);
        chk_en = 2'h3;
        steps(9);
        chk({2'h0, (q[0].size() + q[1].size()) != 0}, 3'h0);
        chk_en = 2'h0;
        $display("default store test done");
        end_of_test();
    end
endmodule // pn_sequence_source_xor_bench

// file: bench/pn_source_properties.sv
// concurrent checks on the sequence source ports
`timescale 1ns/1ps
`include "pn_source_params.svh"
module pn_source_checker (
    input wire logic                    core_clk_i,
    input wire logic                    resetn_i,
    input wire logic [1:0]              bit_clock_i,
    input wire logic [1:0]              sequence_restart_input_i,
    input wire logic [1:0]              restart_button_i,
    input wire logic [1:0]              frame_marker_o,
    input wire logic [1:0]              chip_overflow_o,
    input wire logic [1:0]              xor_a_i,
    input wire logic [1:0]              xor_b_i,
    input wire logic [1:0]              xor_logic_o,
    input wire pn_source_pkg::bipolar_t xor_bipolar_o [2]
);
    import pn_source_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
////////////////////////////////////////////////////////////////////////////////
    a_xor_sum_out: assert property (xor_logic_o == (xor_a_i ^ xor_b_i))
        else $error("xor output wrong");
    a_xor_level_map: assert property (
        xor_bipolar_o[0] == (xor_logic_o[0] ? `PN_BIP_POS : `PN_BIP_NEG))
        else $error("xor level wrong");
    a_second_gate_level: assert property (
        xor_bipolar_o[1] == ((xor_a_i[1] ^ xor_b_i[1]) ? `PN_BIP_POS : `PN_BIP_NEG))
        else $error("second gate level wrong");
    a_frame_holds: assert property (
        $rose(frame_marker_o[0]) |-> frame_marker_o[0] [*6])
        else $error("frame too short");
    // a step from the first bit must take the marker down again
    a_frame_drops: assert property (
        $rose(bit_clock_i[0]) && frame_marker_o[0] && !sequence_restart_input_i[0]
        && !restart_button_i[0] |-> ##[2:6] !frame_marker_o[0])
        else $error("frame too long");
    a_restart_pin_frame: assert property (
        $rose(sequence_restart_input_i[0]) |-> ##[2:6] frame_marker_o[0])
        else $error("restart pin ignored");
    a_button_frame: assert property (
        $rose(restart_button_i[1]) |-> ##[2:6] frame_marker_o[1])
        else $error("button ignored");
    a_overflow_sticky: assert property (chip_overflow_o[0] |=> chip_overflow_o[0])
        else $error("overflow flag lost");
    c_frame_second: cover property ($rose(frame_marker_o[1]));
    c_overflow: cover property ($rose(chip_overflow_o[0]));
    c_xor_high: cover property ($rose(xor_logic_o[1]));
endmodule // pn_source_checker

bind pn_sequence_source_xor pn_source_checker u_pn_source_checker (.*);

// file: hdl/pn_sequence_source_xor.sv
// pseudo-noise sequence source with two generators, two xor gates and chip fifos
// How it works
// RQ1: two separate generators and two xor gates
// RQ2: xor output is combinational from pins
// RQ3: xor result also drives bipolar plus/minus level
// RQ4: one chip per rising edge of bit clock
// RQ5: restart pulse or button returns to bit zero
// RQ6: frame marker high during first bit only
// RQ7: receiver variant drives chips as bipolar level
// RQ8: selector picks one of ten stored sequences
// RQ9: long for 0-3,6,7; short for 4,5,8,9
// RQ10: writable store holds custom sequences
// RQ11: long and short lengths may be equal
// RQ12: user loads same store on both ends
// RQ13: after last bit wrap to first, mark frame
// RQ14: store addressed by selector and bit index
`timescale 1ns/1ps
`include "pn_source_params.svh"

module pn_chip_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16,
    parameter int PTR_W = 4
) (
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W:0]   wr_ptr_r, wr_ptr_nxt;
    logic [PTR_W:0]   rd_ptr_r, rd_ptr_nxt;
    logic             push, pop;

    always_comb begin
        push       = in_valid_i && in_ready_o;
        pop        = out_valid_o && out_ready_i;
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r[PTR_W-1:0]] <= in_data_i;
        end
    end

    // flags come from the pointer flops, data from the storage flops
    assign in_ready_o  = !((wr_ptr_r[PTR_W] != rd_ptr_r[PTR_W]) &&
                           (wr_ptr_r[PTR_W-1:0] == rd_ptr_r[PTR_W-1:0]));
    assign out_valid_o = (wr_ptr_r != rd_ptr_r);
    assign out_data_o  = mem_r[rd_ptr_r[PTR_W-1:0]];
endmodule // pn_chip_fifo

////////////////////////////////////////////////////////////////////////////////

module pn_sequence_source_xor #(
    parameter bit RX_VARIANT = 1'b0
) (
    input  wire logic                          core_clk_i,
    input  wire logic                          resetn_i,
    input  wire logic [`PN_NUM_GEN-1:0]        bit_clock_i,
    input  wire logic [`PN_NUM_GEN-1:0]        sequence_restart_input_i,
    input  wire logic [`PN_NUM_GEN-1:0]        restart_button_i,
    input  wire pn_source_pkg::sel_t           sequence_selector_i [`PN_NUM_GEN],
    input  wire pn_source_pkg::bit_idx_t       long_len_i,
    input  wire pn_source_pkg::bit_idx_t       short_len_i,
    input  wire logic                          use_custom_store_i,
    input  wire pn_source_pkg::store_wr_s      store_wr_i,
    output logic      [`PN_NUM_GEN-1:0]        chip_sequence_out_o,
    output pn_source_pkg::bipolar_t            chip_bipolar_o [`PN_NUM_GEN],
    output logic      [`PN_NUM_GEN-1:0]        frame_marker_o,
    output logic      [`PN_NUM_GEN-1:0]        chip_stream_valid_o,
    input  wire logic [`PN_NUM_GEN-1:0]        chip_stream_ready_i,
    output pn_source_pkg::chip_word_s          chip_stream_data_o [`PN_NUM_GEN],
    output logic      [`PN_NUM_GEN-1:0]        chip_overflow_o,
    input  wire logic [`PN_NUM_GEN-1:0]        xor_a_i,
    input  wire logic [`PN_NUM_GEN-1:0]        xor_b_i,
    output logic      [`PN_NUM_GEN-1:0]        xor_logic_o,
    output pn_source_pkg::bipolar_t            xor_bipolar_o [`PN_NUM_GEN]
);
    import pn_source_pkg::*;

    function automatic logic is_short(input sel_t sel);
        return (sel == 4'h4) || (sel == 4'h5) || (sel == 4'h8) || (sel == 4'h9); // see RQ9
    endfunction

    function automatic bipolar_t to_bipolar(input logic v);
        return v ? `PN_BIP_POS : `PN_BIP_NEG; // see RQ3
    endfunction

    function automatic bit_idx_t lfsr_seed(input sel_t sel);
        return {10'h000, sel} + 14'h0001;
    endfunction

    function automatic bit_idx_t lfsr_step(input bit_idx_t s, input logic short_seq);
        logic     fb;
        bit_idx_t r;
        fb = ^(s & (short_seq ? `PN_SHORT_TAPS : `PN_LONG_TAPS));
        r  = s >> 1;
        if (short_seq) begin
            r[`PN_SHORT_MSB] = fb;
        end else begin
            r[`PN_IDX_W-1] = fb;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // xor gates: no clock on purpose, the gate follows its pins

    always_comb begin
        for (int g = 0; g < `PN_NUM_GEN; g++) begin
            xor_logic_o[g]   = xor_a_i[g] ^ xor_b_i[g];              // see RQ1 see RQ2
            xor_bipolar_o[g] = to_bipolar(xor_a_i[g] ^ xor_b_i[g]);  // see RQ3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // generators

    for (genvar g = 0; g < `PN_NUM_GEN; g++) begin : gen_pn
        // private store per generator, flat index = selector * 2^14 + bit index
        logic       store_r [`PN_NUM_SEQ << `PN_IDX_W];  // see RQ10 see RQ14
        logic [2:0] clk_sync_r, rst_sync_r, btn_sync_r;
        logic [2:0] clk_sync_nxt, rst_sync_nxt, btn_sync_nxt;
        sel_t       sel_meta_r, sel_r;
        bit_idx_t   idx_r, idx_nxt, lfsr_r, lfsr_nxt;
        logic       chip_r, chip_nxt, frame_r, frame_nxt, ovf_r, ovf_nxt;
        logic       step, restart, short_seq, fifo_ready;
        bit_idx_t   last_idx;
        sel_t       sel_clamped;
        chip_word_s word;

        always_comb begin
            // bit 0 of each three-flop chain feeds only bit 1; edges are found on bits 1 and 2
            clk_sync_nxt = {clk_sync_r[1:0], bit_clock_i[g]};
            rst_sync_nxt = {rst_sync_r[1:0], sequence_restart_input_i[g]};
            btn_sync_nxt = {btn_sync_r[1:0], restart_button_i[g]};
            step         = clk_sync_r[1] && !clk_sync_r[2];                 // see RQ4
            restart      = (rst_sync_r[1] && !rst_sync_r[2]) ||
                           (btn_sync_r[1] && !btn_sync_r[2]);               // see RQ5
            sel_clamped  = (sel_r > 4'h9) ? 4'h9 : sel_r;
            short_seq    = is_short(sel_clamped);                           // see RQ9
            // separate length inputs, equal values are fine
            last_idx     = (short_seq ? short_len_i : long_len_i) - 14'h0001; // see RQ11
            idx_nxt      = idx_r;
            lfsr_nxt     = lfsr_r;
            if (restart) begin
                idx_nxt  = '0;
                lfsr_nxt = lfsr_seed(sel_clamped);
            end else if (step) begin
                if (idx_r >= last_idx) begin
                    idx_nxt  = '0;                                          // see RQ13
                    lfsr_nxt = lfsr_seed(sel_clamped);
                end else begin
                    idx_nxt  = idx_r + 14'h0001;
                    lfsr_nxt = lfsr_step(lfsr_r, short_seq);
                end
            end
            chip_nxt  = use_custom_store_i ?
                        store_r[{sel_clamped, idx_nxt}] : lfsr_nxt[0];      // see RQ8 see RQ14
            frame_nxt = (idx_nxt == '0);                                    // see RQ6
            word      = '{frame: frame_nxt, chip: chip_nxt};
            // chips cannot stall the outside clock, so a full fifo drops and flags
            ovf_nxt   = ovf_r || ((step || restart) && !fifo_ready);
        end

        always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                clk_sync_r <= '0;
                rst_sync_r <= '0;
                btn_sync_r <= '0;
                sel_meta_r <= '0;
                sel_r      <= '0;
                idx_r      <= '0;
                lfsr_r     <= 14'h0001;
                chip_r     <= 1'b0;
                frame_r    <= 1'b0;
                ovf_r      <= 1'b0;
            end else begin
                clk_sync_r <= clk_sync_nxt;
                rst_sync_r <= rst_sync_nxt;
                btn_sync_r <= btn_sync_nxt;
                sel_meta_r <= sequence_selector_i[g];
                sel_r      <= sel_meta_r;
                idx_r      <= idx_nxt;
                lfsr_r     <= lfsr_nxt;
                chip_r     <= chip_nxt;
                frame_r    <= frame_nxt;
                ovf_r      <= ovf_nxt;
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (store_wr_i.wr_en && (store_wr_i.gen == 1'(g)) &&
                (store_wr_i.sel < 4'ha)) begin
                store_r[{store_wr_i.sel, store_wr_i.idx}] <= store_wr_i.value; // see RQ10
            end
        end

        pn_chip_fifo #(
            .WIDTH (2),
            .DEPTH (`PN_FIFO_DEPTH),
            .PTR_W (`PN_FIFO_PTR_W)
        ) u_fifo (
            .core_clk_i  (core_clk_i),
            .resetn_i    (resetn_i),
            .in_valid_i  (step || restart),
            .in_ready_o  (fifo_ready),
            .in_data_i   (word),
            .out_valid_o (chip_stream_valid_o[g]),
            .out_ready_i (chip_stream_ready_i[g]),
            .out_data_o  (chip_stream_data_o[g])
        );

        // receiver variant: bipolar chips, unipolar held low
        assign chip_sequence_out_o[g] = RX_VARIANT ? 1'b0 : chip_r;             // see RQ7
        assign chip_bipolar_o[g]      = RX_VARIANT ? to_bipolar(chip_r) : `PN_BIP_ZERO;
        assign frame_marker_o[g]      = frame_r;                                 // see RQ6
        assign chip_overflow_o[g]     = ovf_r;
    end
endmodule // pn_sequence_source_xor

// file: hdl/pn_source_params.svh
// constants for the pseudo-noise sequence source
`ifndef PN_SOURCE_PARAMS_SVH
`define PN_SOURCE_PARAMS_SVH

`define PN_NUM_GEN       2
`define PN_NUM_SEQ       10
`define PN_IDX_W         14
`define PN_SEL_W         4
`define PN_LONG_LEN      14'h3fff
`define PN_SHORT_LEN     14'h007f
`define PN_LONG_TAPS     14'h1007
`define PN_SHORT_TAPS    14'h0003
`define PN_SHORT_MSB     6
`define PN_BIP_POS       3'h2
`define PN_BIP_NEG       3'h6
`define PN_BIP_ZERO      3'h0
`define PN_FIFO_DEPTH    16
`define PN_FIFO_PTR_W    4

`endif

// file: hdl/pn_source_pkg.sv
// types shared by the pseudo-noise sequence source
package pn_source_pkg;
    typedef logic [13:0] bit_idx_t;
    typedef logic [3:0]  sel_t;
    typedef logic [2:0]  bipolar_t;

    typedef struct packed {
        logic frame;
        logic chip;
    } chip_word_s;

    typedef struct packed {
        logic     wr_en;
        logic     gen;
        sel_t     sel;
        bit_idx_t idx;
        logic     value;
    } store_wr_s;
endpackage
